/* File: hdl/bfk_defs.vh */
`ifndef BFK_DEFS_VH
`define BFK_DEFS_VH

// ****************************************
// Field geometry
// ****************************************
`define BFK_FIELD_BITS     388
`define BFK_CTRL_BITS      64
`define BFK_PAY_BITS       324
`define BFK_HDR_BITS       8
`define BFK_TAIL_BITS      40
`define BFK_CCRC_BITS      16
`define BFK_DATA_BITS      320
`define BFK_XCRC_BITS      4
`define BFK_TAIL_LSB       8
`define BFK_PAY_LSB        64
`define BFK_SUB_PITCH      80
`define BFK_SUB_DATA       64
`define BFK_SUB_CRC        16
`define BFK_SINGLE_DATA    304

// ****************************************
// Keystream geometry
// ****************************************
`define BFK_SEG_BITS       360
`define BFK_PAIR_BITS      720
`define BFK_SEG_PAY_OFS    40

// ****************************************
// Header code fields
// ****************************************
`define BFK_HDR_TAIL_LSB   1
`define BFK_HDR_TAIL_W     3
`define BFK_HDR_BTYPE_LSB  4
`define BFK_HDR_BTYPE_W    3

// ****************************************
// Connection service types
// ****************************************
`define BFK_SVC_UNPROT     2'h0
`define BFK_SVC_MULTI      2'h1
`define BFK_SVC_SINGLE     2'h2
`define BFK_SVC_ENCODED    2'h3

// ****************************************
// Payload formats after decode
// ****************************************
`define BFK_FMT_UNPROT     2'h0
`define BFK_FMT_MULTI      2'h1
`define BFK_FMT_SINGLE     2'h2
`define BFK_FMT_ENCODED    2'h3

`endif

/* File: hdl/bfk_bit_cipher.v */
`timescale 1ns/10ps
`include "bfk_defs.vh"

// ****************************************
// One payload data bit: eligibility and XOR
// ****************************************
module bfk_bit_cipher #(
  parameter K = 0
) (
  fmt,
  enc_len,
  cipher_on,
  ks_bit,
  in_bit,
  out_bit
);
  input  wire [1:0] fmt;
  input  wire [8:0] enc_len;
  input  wire       cipher_on;
  input  wire       ks_bit;
  input  wire       in_bit;
  output wire       out_bit;

  localparam IN_DATA   = (K < `BFK_DATA_BITS);
  localparam IN_SINGLE = (K < `BFK_SINGLE_DATA);
  localparam IN_SUB    = ((K % `BFK_SUB_PITCH) < `BFK_SUB_DATA) && IN_DATA;

  reg eligible;

  always @* begin
    case (fmt)
      `BFK_FMT_UNPROT:  eligible = IN_DATA;
      `BFK_FMT_SINGLE:  eligible = IN_SINGLE;
      `BFK_FMT_MULTI:   eligible = IN_SUB;
      `BFK_FMT_ENCODED: eligible = IN_DATA && (K < enc_len);
      default:          eligible = 1'b0;
    endcase
  end

  // Check bits and the trailing X bits never see keystream
  assign out_bit = in_bit ^ (ks_bit & eligible & cipher_on);

endmodule

/* File: hdl/bfk_keystream_xor.v */
`timescale 1ns/10ps
`include "bfk_defs.vh"


module bfk_keystream_xor #(
  parameter [2:0] TAIL_CIPHER_CODE = 3'h7,
  parameter [2:0] BTYPE_U_CODE     = 3'h0,
  parameter [2:0] BTYPE_E_CODE     = 3'h1,
  parameter [2:0] BTYPE_EU_CODE    = 3'h2
) (
  core_clk,
  rst_n,
  fixed_side,
  cipher_on,
  fld_valid,
  fld_ready,
  fld_tx,
  fld_service,
  fld_enc_len,
  fld_data,
  ks_valid,
  ks_ready,
  ks_pair,
  out_valid,
  out_tx,
  out_data
);
  input  wire                        core_clk;
  input  wire                        rst_n;
  input  wire                        fixed_side;
  input  wire                        cipher_on;
  input  wire                        fld_valid;
  output wire                        fld_ready;
  input  wire                        fld_tx;
  input  wire [1:0]                  fld_service;
  input  wire [8:0]                  fld_enc_len;
  input  wire [`BFK_FIELD_BITS-1:0]  fld_data;
  input  wire                        ks_valid;
  output wire                        ks_ready;
  input  wire [`BFK_PAIR_BITS-1:0]   ks_pair;
  output wire                        out_valid;
  output wire                        out_tx;
  output wire [`BFK_FIELD_BITS-1:0]  out_data;

  // ****************************************
  // Field split
  // ****************************************
  wire [`BFK_HDR_BITS-1:0]    hdr_bits;
  wire [`BFK_TAIL_BITS-1:0]   tail_bits;
  wire [`BFK_CCRC_BITS-1:0]   ccrc_bits;
  wire [`BFK_PAY_BITS-1:0]    pay_bits;
  wire [`BFK_HDR_TAIL_W-1:0]  tail_code;
  wire [`BFK_HDR_BTYPE_W-1:0] btype_code;

  assign hdr_bits   = fld_data[`BFK_HDR_BITS-1:0];
  assign tail_bits  = fld_data[`BFK_TAIL_LSB +: `BFK_TAIL_BITS];
  assign ccrc_bits  = fld_data[`BFK_CTRL_BITS-1 -: `BFK_CCRC_BITS];
  assign pay_bits   = fld_data[`BFK_PAY_LSB +: `BFK_PAY_BITS];
  assign tail_code  = hdr_bits[`BFK_HDR_TAIL_LSB +: `BFK_HDR_TAIL_W];
  assign btype_code = hdr_bits[`BFK_HDR_BTYPE_LSB +: `BFK_HDR_BTYPE_W];

  // ****************************************
  // Format decode
  // ****************************************
  reg  [1:0] svc_fmt;
  reg  [1:0] fmt;
  wire       tail_cipher;

  always @* begin
    case (fld_service)
      `BFK_SVC_UNPROT:  svc_fmt = `BFK_FMT_UNPROT;
      `BFK_SVC_MULTI:   svc_fmt = `BFK_FMT_MULTI;
      `BFK_SVC_SINGLE:  svc_fmt = `BFK_FMT_SINGLE;
      `BFK_SVC_ENCODED: svc_fmt = `BFK_FMT_ENCODED;
      default:          svc_fmt = `BFK_FMT_UNPROT;
    endcase
  end

  // Control and mixed payloads always use the multi-CRC map
  always @* begin
    case (btype_code)
      BTYPE_E_CODE:  fmt = `BFK_FMT_MULTI;
      BTYPE_EU_CODE: fmt = `BFK_FMT_MULTI;
      BTYPE_U_CODE:  fmt = svc_fmt;
      default:       fmt = svc_fmt;
    endcase
  end

  assign tail_cipher = (tail_code == TAIL_CIPHER_CODE);

  // ****************************************
  // Segment select
  // ****************************************
  wire                      use_first;
  wire [`BFK_SEG_BITS-1:0]  seg;

  // Bit 0 of each half is the earliest generator output
  assign use_first = fixed_side ? fld_tx : ~fld_tx;
  assign seg = use_first ? ks_pair[`BFK_SEG_BITS-1:0]
                         : ks_pair[`BFK_PAIR_BITS-1:`BFK_SEG_BITS];

  // ****************************************
  // Handshake
  // ****************************************
  wire take;

  // Keystream is neither waited for nor consumed while ciphering is off
  assign fld_ready = cipher_on ? ks_valid : 1'b1;
  assign take      = fld_valid & fld_ready;
  assign ks_ready  = fld_valid & cipher_on;

  // ****************************************
  // Tail cipher
  // ****************************************
  wire [`BFK_TAIL_BITS-1:0] tail_out;

  // Segment bits 0..39 are dropped for non-ciphered tail types
  assign tail_out = tail_bits ^ (seg[`BFK_TAIL_BITS-1:0]
                    & {`BFK_TAIL_BITS{tail_cipher & cipher_on}});

  // ****************************************
  // Payload cipher
  // ****************************************
  wire [`BFK_PAY_BITS-1:0] pay_out;

  genvar k;
  generate
    for (k = 0; k < `BFK_DATA_BITS; k = k + 1) begin : g_pay
      bfk_bit_cipher #(
        .K (k)
      ) u_bit (
        .fmt       (fmt),
        .enc_len   (fld_enc_len),
        .cipher_on (cipher_on),
        .ks_bit    (seg[`BFK_SEG_PAY_OFS + k]),
        .in_bit    (pay_bits[k]),
        .out_bit   (pay_out[k])
      );
    end
  endgenerate

  // Trailing 4-bit payload CRC passes untouched
  assign pay_out[`BFK_PAY_BITS-1:`BFK_DATA_BITS] =
           pay_bits[`BFK_PAY_BITS-1:`BFK_DATA_BITS];

  // ****************************************
  // Output stage
  // ****************************************
  reg                        out_valid_reg;
  reg                        out_tx_reg;
  reg  [`BFK_FIELD_BITS-1:0] out_data_reg;
  wire [`BFK_FIELD_BITS-1:0] out_data_next;

  // Header and control CRC are copied straight through
  assign out_data_next = {pay_out, ccrc_bits, tail_out, hdr_bits};

  // On transmit the CRC stage downstream sees ciphered bits; on receive the
  // CRC stage upstream has already checked the ciphered bits
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_tx_reg    <= 1'b0;
      out_data_reg  <= {`BFK_FIELD_BITS{1'b0}};
    end else begin
      out_valid_reg <= take;
      if (take) begin
        out_tx_reg   <= fld_tx;
        out_data_reg <= out_data_next;
      end
    end
  end

  assign out_valid = out_valid_reg;
  assign out_tx    = out_tx_reg;
  assign out_data  = out_data_reg;

endmodule

/* File: testbench/bfk_ks_src.sv */
`timescale 1ns/10ps
`include "bfk_defs.vh"
// ****************************************
// Keystream source
// ****************************************
module bfk_ks_src (
  input  wire                      stall,
  input  wire [7:0]                iv,
  output reg                       ks_valid,
  output reg  [`BFK_PAIR_BITS-1:0] ks_pair
);
  integer j;
  always @* begin
    ks_valid = !stall;
    for (j = 0; j < `BFK_PAIR_BITS; j = j + 1)
      ks_pair[j] = ^(iv & (j[7:0] ^ j[10:3])) ^ stall;
  end
endmodule

/* File: testbench/bfk_keystream_xor_sva.sv */
`timescale 1ns/10ps
`include "bfk_defs.vh"
// ****************************************
// Port checker
// ****************************************
module bfk_keystream_xor_chk #(
  parameter [2:0] TAIL_CIPHER_CODE = 3'h7,
  parameter [2:0] BTYPE_E_CODE     = 3'h1,
  parameter [2:0] BTYPE_EU_CODE    = 3'h2
) (
  input wire         core_clk,
  input wire         rst_n,
  input wire         cipher_on,
  input wire         fld_valid,
  input wire         fld_ready,
  input wire         fld_tx,
  input wire [387:0] fld_data,
  input wire         ks_valid,
  input wire         ks_ready,
  input wire         out_valid,
  input wire         out_tx,
  input wire [387:0] out_data
);
  wire take = fld_valid && fld_ready;
  wire mux_e = (fld_data[6:4] == BTYPE_E_CODE) || (fld_data[6:4] == BTYPE_EU_CODE);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  take_resp_a: assert property (take |=> out_valid) else $error("no answer");
  idle_quiet_a: assert property (!take |=> !out_valid) else $error("stray answer");
  stall_ready_a: assert property (cipher_on |-> fld_ready == ks_valid)
    else $error("ready not tied to keystream");
  off_ready_a: assert property (!cipher_on |-> fld_ready && !ks_ready)
    else $error("keystream used while off");
  ks_use_a: assert property (ks_ready == (fld_valid && cipher_on))
    else $error("keystream take wrong");
  hdr_crc_a: assert property (take |=> out_data[7:0] == $past(fld_data[7:0])
    && out_data[63:48] == $past(fld_data[63:48])) else $error("header or crc changed");
  xcrc_keep_a: assert property (take |=> out_data[387:384] == $past(fld_data[387:384]))
    else $error("payload crc changed");
  tail_plain_a: assert property (take && fld_data[3:1] != TAIL_CIPHER_CODE |=>
    out_data[47:8] == $past(fld_data[47:8])) else $error("plain tail changed");
  sub_crc_a: assert property (take && mux_e |=>
    out_data[143:128] == $past(fld_data[143:128])) else $error("subfield crc changed");
  off_pass_a: assert property (take && !cipher_on |=> out_data == $past(fld_data))
    else $error("field altered while off");
  out_hold_a: assert property (!take |=> $stable(out_data) && $stable(out_tx))
    else $error("output moved without take");
  tx_echo_a: assert property (take |=> out_tx == $past(fld_tx))
    else $error("direction not echoed");
endmodule
bind bfk_keystream_xor bfk_keystream_xor_chk #(.TAIL_CIPHER_CODE(TAIL_CIPHER_CODE),
  .BTYPE_E_CODE(BTYPE_E_CODE), .BTYPE_EU_CODE(BTYPE_EU_CODE))
  i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .cipher_on(cipher_on), .fld_valid(fld_valid), .fld_ready(fld_ready), .fld_tx(fld_tx),
  .fld_data(fld_data), .ks_valid(ks_valid), .ks_ready(ks_ready), .out_valid(out_valid),
  .out_tx(out_tx), .out_data(out_data));

/* File: testbench/burst_field_keystream_xor_bench.sv */
`timescale 1ns/10ps
`include "bfk_defs.vh"
`define CHK(a, b) begin cmp_count = cmp_count + 1; if ((a) !== (b)) begin \
  err_total = err_total + 1; $display("FAIL %0t value mismatch", $time); end end
// ****************************************
// Bench
// ****************************************
module burst_field_keystream_xor_bench;
  reg          core_clk, rst_n, fixed_side, cipher_on, fld_valid, fld_tx, stall;
  reg  [1:0]   fld_service;
  reg  [8:0]   fld_enc_len;
  reg  [7:0]   iv;
  reg  [387:0] fld_data, want;
  wire         fld_ready, ks_valid, ks_ready, out_valid, out_tx;
  wire [719:0] ks_pair;
  wire [387:0] out_data;
  integer      err_total, cmp_count;
  bfk_ks_src i_bfk_ks_src (.stall(stall), .iv(iv), .ks_valid(ks_valid), .ks_pair(ks_pair));
  bfk_keystream_xor i_bfk_keystream_xor (.core_clk(core_clk), .rst_n(rst_n),
    .fixed_side(fixed_side), .cipher_on(cipher_on), .fld_valid(fld_valid),
    .fld_ready(fld_ready), .fld_tx(fld_tx), .fld_service(fld_service),
    .fld_enc_len(fld_enc_len), .fld_data(fld_data), .ks_valid(ks_valid),
    .ks_ready(ks_ready), .ks_pair(ks_pair), .out_valid(out_valid), .out_tx(out_tx),
    .out_data(out_data));
  function [387:0] ref_out(input [387:0] f, input [719:0] p, input fx, tx, on,
                           input [1:0] sv, input [8:0] n);
    reg [359:0] s;
    reg [1:0]   fm;
    integer     k;
    begin
      ref_out = f;
      s = (fx == tx) ? p[359:0] : p[719:360];
      fm = (f[6:4] == 3'h1 || f[6:4] == 3'h2) ? 2'h1 : sv;
      if (on && f[3:1] == 3'h7)
        ref_out[47:8] = f[47:8] ^ s[39:0];
      for (k = 0; k < 320; k = k + 1)
        if (on && (fm == 0 || (fm == 2 && k < 304) || (fm == 1 && k % 80 < 64)
            || (fm == 3 && k < n)))
          ref_out[64 + k] = f[64 + k] ^ s[40 + k];
    end
  endfunction
  task xfer(input [387:0] f, input fx, on, tx, input [1:0] sv, input [8:0] n,
            input [7:0] v, input integer stl);
    integer w;
    begin
      fld_data = f;
      fixed_side = fx;
      cipher_on = on;
      fld_tx = tx;
      fld_service = sv;
      fld_enc_len = n;
      iv = v;
      fld_valid = 1'b1;
      stall = (stl > 0) || !on;
      for (w = 0; w < stl; w = w + 1) begin
        @(negedge core_clk);
        `CHK(fld_ready, 1'b0)
      end
      if (stl > 0)
        stall = 1'b0;
      #1;
      `CHK(ks_ready, on)
      want = ref_out(f, ks_pair, fx, tx, on, sv, n);
      @(negedge core_clk);
      `CHK(out_valid, 1'b1)
      `CHK(out_tx, tx)
      `CHK(out_data, want)
    end
  endtask
  task t_unprot;
    xfer({{95{4'h5}}, 8'h0e}, 1, 1, 1, 2'h0, 9'h0, 8'ha5, 0);
  endtask
  task t_fixed_rx;
    xfer({{95{4'ha}}, 8'h0e}, 1, 1, 0, 2'h0, 9'h0, 8'h3c, 0);
  endtask
  task t_multi;
    xfer({{95{4'h9}}, 8'h04}, 0, 1, 1, 2'h1, 9'h0, 8'hc3, 0);
  endtask
  task t_single;
    xfer({{95{4'h6}}, 8'h0e}, 1, 1, 0, 2'h2, 9'h0, 8'h5a, 3);
  endtask
  task t_enc;
    begin
      xfer({{95{4'hf}}, 8'h0e}, 0, 1, 0, 2'h3, 9'ha0, 8'h96, 0);
      xfer({{95{4'h1}}, 8'h00}, 0, 1, 1, 2'h3, 9'h140, 8'h69, 0);
    end
  endtask
  task t_emux;
    begin
      xfer({{95{4'h7}}, 8'h10}, 1, 1, 1, 2'h0, 9'h0, 8'he1, 0);
      xfer({{95{4'hb}}, 8'h2e}, 1, 1, 1, 2'h3, 9'h0, 8'h1e, 0);
      xfer({{95{4'hd}}, 8'h30}, 0, 1, 0, 2'h2, 9'h0, 8'h87, 0);
    end
  endtask
  task t_off;
    xfer({{95{4'he}}, 8'h0e}, 1, 0, 1, 2'h0, 9'h0, 8'hff, 0);
  endtask
  task t_reset;
    begin
      fld_valid = 1'b0;
      rst_n = 1'b0;
      #1;
      `CHK(out_valid, 1'b0)
      `CHK(out_tx, 1'b0)
      `CHK(out_data, 388'h0)
      @(negedge core_clk);
      `CHK(out_data, 388'h0)
      rst_n = 1'b1;
    end
  endtask
  task t_twice;
    begin
      xfer({{95{4'h3}}, 8'h0e}, 1, 1, 1, 2'h1, 9'h0, 8'h77, 0);
      xfer(out_data, 0, 1, 0, 2'h1, 9'h0, 8'h77, 0);
      `CHK(out_data, {{95{4'h3}}, 8'h0e})
    end
  endtask
  task wrap_up;
    begin
      $display("Mismatches %0d, comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #20000;
    err_total = err_total + 1;
    wrap_up;
  end
  initial begin
    {err_total, cmp_count} = 0;
    {rst_n, fixed_side, cipher_on, fld_valid, fld_tx, stall} = 6'h0;
    {fld_service, fld_enc_len, iv, fld_data} = 0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    t_unprot;
    t_fixed_rx;
    t_multi;
    t_single;
    t_enc;
    t_reset;
    t_emux;
    t_off;
    t_twice;
    fld_valid = 1'b0;
    @(negedge core_clk);
    `CHK(out_valid, 1'b0)
    `CHK(out_data, want)
    wrap_up;
  end
endmodule
